// >>> dtm_regs.svh
`ifndef DTM_REGS_SVH
`define DTM_REGS_SVH
// Register indices; the byte address is four times the index.
`define DTM_IDX_TIMER_CONTROL_REGISTER  10'h088
`define DTM_IDX_TIMER_MODE_REGISTER  10'h089
`define DTM_IDX_TL0   10'h08A
`define DTM_IDX_TL1   10'h08B
`define DTM_IDX_TH0   10'h08C
`define DTM_IDX_TH1   10'h08D
`define DTM_IDX_TIMER2_CONTROL 10'h0C8
`define DTM_IDX_TIMER2_MODE_CONTROL 10'h0C9
`define DTM_IDX_T2RLD 10'h0CA
`define DTM_IDX_T2CNT 10'h0CC
// Mode register fields.
`define DTM_T0_MODE   0
`define DTM_T0_FN     2
`define DTM_T0_GATE   3
`define DTM_T1_MODE   4
`define DTM_T1_FN     6
`define DTM_T1_GATE   7
// Timer 2 control and mode control fields.
`define DTM_T2_TF     7
`define DTM_T2_EXF    6
`define DTM_T2_RCLK   5
`define DTM_T2_UART_TRANSMIT_CLOCK_SELECT   4
`define DTM_T2_EXEN   3
`define DTM_T2_RUN    2
`define DTM_T2_FN     1
`define DTM_T2_CPRL   0
`define DTM_T2_OE     1
`define DTM_T2_DOWN_COUNT_ENABLE   0
// Synchronised pin positions.
`define DTM_P_T0      0
`define DTM_P_T1      1
`define DTM_P_INT0    2
`define DTM_P_INT1    3
`define DTM_P_T2      4
`define DTM_P_TIMER2_TRIGGER_PIN    5
`define DTM_RESET_BYTE 8'h00
`define DTM_MC_DIV    6
`endif

// >>> dtm_pkg.sv
package dtm_pkg;
  typedef enum logic [4:0] {
    T2_OFF  = 5'h01,
    T2_ARL  = 5'h02,
    T2_CAP  = 5'h04,
    T2_CLK  = 5'h08,
    T2_BAUD = 5'h10
  } dtm_t2mode_type;
endpackage

// >>> dtm_timers.sv
`timescale 1ns/1ns
`include "dtm_regs.svh"
// Function
// - Timer counts machine cycles, counter counts falling pins
// - Two-bit mode field and function bit per timer
// - Mode 0 is thirteen bits, upper low bits ignored
// - Rollover to zero sets the overflow flag
// - Count only when run and gate-or-pin allow
// - Setting run bit keeps the count
// - Gate bits at mode bits seven and three
// - Mode 1 uses full sixteen bits
// - Mode 2 reloads low byte from high
// - Timer 1 in mode 3 holds count
// - Timer 0 mode 3 low byte keeps own controls
// - Timer 0 high byte uses Timer 1 run, flag
// - Timer 1 run follows its mode 3, baud stays
// - Timer 2 mode chosen from run, clocks, bits
// - Timer 2 overflow flag blocked in baud, clock-out
// - Trigger falling edge sets external flag when enabled, except in clock-out mode or with Timer 2 stopped
// - Clock-select bits pick Timer 2 baud pulses
// - Trigger enable allows capture or reload
// - Timer 2 runs only with run bit
// - Timer 2 function picks tick or pin edges
// - Capture/reload bit ignored in baud mode
// - Output enable acts only in clock-out mode
// - Down-count enable allows up/down counting
// - Vector acknowledge or software clears Timer 0/1 overflow flags; Timer 2 flag cleared by software only
module dtm_timers #(
  parameter int MC_DIV = `DTM_MC_DIV
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // External pins
  input  wire logic        t0_count_pin,
  input  wire logic        t1_count_pin,
  input  wire logic        external_interrupt_pin0_n,
  input  wire logic        external_interrupt_pin1_n,
  input  wire logic        t2_count_pin,
  input  wire logic        timer2_trigger_pin,
  output logic             t2_clock_out,
  output logic             t2_clock_out_en,
  // Processor side
  input  wire logic        t0_vector_ack,
  input  wire logic        t1_vector_ack,
  output logic             timer0_overflow_flag,
  output logic             timer1_overflow_flag,
  output logic             timer2_interrupt_request,
  output logic             uart_rx_baud_pulse,
  output logic             uart_tx_baud_pulse
);
  // The divider is sized from the machine-cycle length, so a long machine cycle still divides exactly.
  localparam int            TW     = (MC_DIV > 2) ? $clog2(MC_DIV) : 1;
  localparam logic [TW-1:0] DIV_M1 = TW'(MC_DIV - 1);

  typedef struct packed {
    logic [TW-1:0] tick_cnt;
    logic [5:0]  s1;
    logic [5:0]  s2;
    logic [5:0]  prev;
    logic [7:0]  timer_mode_register;
    logic        tf0;
    logic        tr0;
    logic        tf1;
    logic        tr1;
    logic [7:0]  tl0;
    logic [7:0]  th0;
    logic [7:0]  tl1;
    logic [7:0]  th1;
    logic [7:0]  timer2_control;
    logic [1:0]  timer2_mode_control;
    logic [15:0] t2cnt;
    logic [15:0] t2rld;
    logic        clk_out;
    logic        clk_oe;
    logic        irq2;
    logic        rxp;
    logic        txp;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } dtm_state_type;

  dtm_state_type q;
  dtm_state_type n;
  logic [5:0]  pins;
  logic [5:0]  fall;
  logic        tick;
  logic        wr;
  logic        inc0;
  logic        set0;
  logic        t0m3;
  logic [9:0]  idx;
  dtm_pkg::dtm_t2mode_type t2m;

  // Returns {overflow, high, low} after one count step.
  function automatic logic [16:0] dtm_step(input logic [1:0] mode, input logic [7:0] th, input logic [7:0] tl);
    logic [12:0] v;
    logic [15:0] w;
    v = {th, tl[4:0]} + 13'h0001;
    w = {th, tl} + 16'h0001;
    unique case (mode)
      2'h0:    dtm_step = {&{th, tl[4:0]}, v[12:5], tl[7:5], v[4:0]};
      2'h1:    dtm_step = {&{th, tl}, w};
      2'h2:    dtm_step = (&tl) ? {1'b1, th, th} : {1'b0, th, w[7:0]};
      2'h3:    dtm_step = {&tl, th, w[7:0]};
    endcase
  endfunction

  assign pins = {timer2_trigger_pin, t2_count_pin, external_interrupt_pin1_n,
                 external_interrupt_pin0_n, t1_count_pin, t0_count_pin};
  assign idx  = paddr[11:2];

  always_comb
  begin
    logic [1:0]  m0;
    logic [1:0]  m1;
    logic [16:0] r0;
    logic [16:0] r1;
    logic        hinc;
    logic        en1;
    logic        inc1;
    logic        t1ovf;
    logic        set1;
    logic        inc2;
    logic        dn;
    logic        ev;
    logic        trig;
    logic        setx;
    logic        setf2;
    logic        setup;
    logic        hit;
    logic [31:0] rd;
    {m0, m1, r0, r1, hinc, en1, inc1, t1ovf, set1, inc2, dn, ev, trig, setx, setf2, setup, hit, rd} = '0;
    n = q;
    tick = q.tick_cnt == DIV_M1;
    n.tick_cnt = tick ? '0 : q.tick_cnt + TW'(1);
    n.s1 = pins;
    n.s2 = q.s1;
    if (tick)
    begin
      n.prev = q.s2;
    end
    // Pins are sampled once per machine cycle; a high then low sample is an edge.
    fall = {6{tick}} & q.prev & ~q.s2;
    wr = psel & penable & q.pready & pwrite;
    m0 = q.timer_mode_register[`DTM_T0_MODE +: 2];
    m1 = q.timer_mode_register[`DTM_T1_MODE +: 2];
    t0m3 = m0 == 2'h3;
    // Run bits only gate counting; the count itself is never cleared here.
    inc0 = q.tr0 & (~q.timer_mode_register[`DTM_T0_GATE] | q.s2[`DTM_P_INT0])
         & (q.timer_mode_register[`DTM_T0_FN] ? fall[`DTM_P_T0] : tick);
    r0 = dtm_step(m0, q.th0, q.tl0);
    if (inc0)
    begin
      n.tl0 = r0[7:0];
      if (!t0m3)
      begin
        n.th0 = r0[15:8];
      end
    end
    hinc = t0m3 & q.tr1 & tick;
    if (hinc)
    begin
      n.th0 = q.th0 + 8'h01;
    end
    en1 = (t0m3 | q.tr1) & (m1 != 2'h3);
    inc1 = en1 & (~q.timer_mode_register[`DTM_T1_GATE] | q.s2[`DTM_P_INT1])
         & (q.timer_mode_register[`DTM_T1_FN] ? fall[`DTM_P_T1] : tick);
    r1 = dtm_step(m1, q.th1, q.tl1);
    if (inc1)
    begin
      n.th1 = r1[15:8];
      n.tl1 = r1[7:0];
    end
    t1ovf = inc1 & r1[16];
    set0 = inc0 & r0[16];
    set1 = (hinc & (&q.th0)) | (t1ovf & ~t0m3);
    n.tf0 = q.tf0 & ~t0_vector_ack;
    n.tf1 = q.tf1 & ~t1_vector_ack;
    if (!q.timer2_control[`DTM_T2_RUN])
      t2m = dtm_pkg::T2_OFF;
    else if (q.timer2_control[`DTM_T2_RCLK] | q.timer2_control[`DTM_T2_UART_TRANSMIT_CLOCK_SELECT])
      t2m = dtm_pkg::T2_BAUD;
    else if (q.timer2_control[`DTM_T2_CPRL])
      t2m = dtm_pkg::T2_CAP;
    else if (q.timer2_mode_control[`DTM_T2_OE])
      t2m = dtm_pkg::T2_CLK;
    else
      t2m = dtm_pkg::T2_ARL;
    inc2 = q.timer2_control[`DTM_T2_RUN]
         & (q.timer2_control[`DTM_T2_FN] ? fall[`DTM_P_T2] : tick);
    dn = q.timer2_mode_control[`DTM_T2_DOWN_COUNT_ENABLE] & (t2m == dtm_pkg::T2_ARL) & ~q.s2[`DTM_P_TIMER2_TRIGGER_PIN];
    ev = 1'b0;
    if (inc2)
    begin
      if (dn)
      begin
        ev = q.t2cnt == q.t2rld;
        n.t2cnt = ev ? 16'hFFFF : q.t2cnt - 16'h0001;
      end
      else
      begin
        ev = &q.t2cnt;
        n.t2cnt = !ev ? q.t2cnt + 16'h0001 : (t2m == dtm_pkg::T2_CAP) ? 16'h0000 : q.t2rld;
      end
    end
    // While the serial port is clocked the trigger only raises the flag.
    trig = fall[`DTM_P_TIMER2_TRIGGER_PIN] & q.timer2_control[`DTM_T2_EXEN];
    if (trig && t2m == dtm_pkg::T2_CAP)
    begin
      n.t2rld = q.t2cnt;
    end
    if (trig && t2m == dtm_pkg::T2_ARL)
    begin
      n.t2cnt = q.t2rld;
    end
    setx = trig & (t2m inside {dtm_pkg::T2_CAP, dtm_pkg::T2_ARL, dtm_pkg::T2_BAUD});
    setf2 = ev & (t2m inside {dtm_pkg::T2_CAP, dtm_pkg::T2_ARL});
    if (ev && t2m == dtm_pkg::T2_CLK)
    begin
      n.clk_out = ~q.clk_out;
    end
    n.clk_oe = t2m == dtm_pkg::T2_CLK;
    n.rxp = q.timer2_control[`DTM_T2_RCLK] ? ev : t1ovf;
    n.txp = q.timer2_control[`DTM_T2_UART_TRANSMIT_CLOCK_SELECT] ? ev : t1ovf;
    if (wr)
    begin
      case (idx)
        `DTM_IDX_TIMER_CONTROL_REGISTER:  {n.tf1, n.tr1, n.tf0, n.tr0} = pwdata[7:4];
        `DTM_IDX_TIMER_MODE_REGISTER:  n.timer_mode_register = pwdata[7:0];
        `DTM_IDX_TL0:   n.tl0 = pwdata[7:0];
        `DTM_IDX_TL1:   n.tl1 = pwdata[7:0];
        `DTM_IDX_TH0:   n.th0 = pwdata[7:0];
        `DTM_IDX_TH1:   n.th1 = pwdata[7:0];
        `DTM_IDX_TIMER2_CONTROL: n.timer2_control = pwdata[7:0];
        `DTM_IDX_TIMER2_MODE_CONTROL: n.timer2_mode_control = pwdata[1:0];
        `DTM_IDX_T2RLD: n.t2rld = pwdata[15:0];
        `DTM_IDX_T2CNT: n.t2cnt = pwdata[15:0];
        default:        n.pslverr = 1'b0;
      endcase
    end
    // A hardware set in the same cycle as a clear always survives.
    n.tf0 = n.tf0 | set0;
    n.tf1 = n.tf1 | set1;
    n.timer2_control[`DTM_T2_TF] = n.timer2_control[`DTM_T2_TF] | setf2;
    n.timer2_control[`DTM_T2_EXF] = n.timer2_control[`DTM_T2_EXF] | setx;
    n.irq2 = n.timer2_control[`DTM_T2_TF] | n.timer2_control[`DTM_T2_EXF];
    hit = 1'b1;
    rd = 32'h0000_0000;
    case (idx)
      `DTM_IDX_TIMER_CONTROL_REGISTER:  rd[7:0] = {q.tf1, q.tr1, q.tf0, q.tr0, 4'h0};
      `DTM_IDX_TIMER_MODE_REGISTER:  rd[7:0] = q.timer_mode_register;
      `DTM_IDX_TL0:   rd[7:0] = q.tl0;
      `DTM_IDX_TL1:   rd[7:0] = q.tl1;
      `DTM_IDX_TH0:   rd[7:0] = q.th0;
      `DTM_IDX_TH1:   rd[7:0] = q.th1;
      `DTM_IDX_TIMER2_CONTROL: rd[7:0] = q.timer2_control;
      `DTM_IDX_TIMER2_MODE_CONTROL: rd[1:0] = q.timer2_mode_control;
      `DTM_IDX_T2RLD: rd[15:0] = q.t2rld;
      `DTM_IDX_T2CNT: rd[15:0] = q.t2cnt;
      default:        hit = 1'b0;
    endcase
    setup = psel & ~penable;
    n.pready = setup;
    n.pslverr = setup & ~hit;
    if (setup)
    begin
      n.prdata = rd;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= n;
  end

  assign prdata                   = q.prdata;
  assign pready                   = q.pready;
  assign pslverr                  = q.pslverr;
  assign t2_clock_out             = q.clk_out;
  assign t2_clock_out_en          = q.clk_oe;
  assign timer0_overflow_flag     = q.tf0;
  assign timer1_overflow_flag     = q.tf1;
  assign timer2_interrupt_request = q.irq2;
  assign uart_rx_baud_pulse       = q.rxp;
  assign uart_tx_baud_pulse       = q.txp;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence timer2_trigger_pin_fall_seq;
    tick && q.prev[`DTM_P_TIMER2_TRIGGER_PIN] && !q.s2[`DTM_P_TIMER2_TRIGGER_PIN] && q.timer2_control[`DTM_T2_EXEN];
  endsequence
  sequence t2_cap_seq;
    q.timer2_control[`DTM_T2_RUN] && q.timer2_control[`DTM_T2_CPRL] && !q.timer2_control[`DTM_T2_RCLK] && !q.timer2_control[`DTM_T2_UART_TRANSMIT_CLOCK_SELECT];
  endsequence

  run_gate_a: assert property (!q.tr0 && !wr |=> $stable(q.tl0)) else $error("count moved with run low");
  pin_gate_a: assert property (q.timer_mode_register[`DTM_T0_GATE] && !q.s2[`DTM_P_INT0] && !wr |=> $stable(q.tl0))
    else $error("count moved with gate pin low");
  mode1_ovf_a: assert property (inc0 && q.timer_mode_register[1:0] == 2'h1 && {q.th0, q.tl0} == 16'hFFFF |=> q.tf0 && q.tl0 == 8'h00)
    else $error("mode 1 rollover missed");
  mode0_carry_a: assert property (inc0 && q.timer_mode_register[1:0] == 2'h0 && q.tl0[4:0] == 5'h1F && !wr
    |=> q.th0 == $past(q.th0) + 8'h01 && q.tl0[4:0] == 5'h00) else $error("mode 0 carry wrong");
  mode2_reload_a: assert property (inc0 && q.timer_mode_register[1:0] == 2'h2 && q.tl0 == 8'hFF && !wr
    |=> q.tl0 == $past(q.th0) && $stable(q.th0) && q.tf0) else $error("mode 2 reload wrong");
  t1_hold_a: assert property (q.timer_mode_register[5:4] == 2'h3 && !wr |=> $stable({q.th1, q.tl1}))
    else $error("timer 1 counted in mode 3");
  split_high_a: assert property (t0m3 && q.tr1 && tick && q.th0 == 8'hFF |=> q.tf1 && q.th0 == 8'h00)
    else $error("split high byte overflow missed");
  tf2_block_a: assert property ((q.timer2_control[`DTM_T2_RCLK] || q.timer2_control[`DTM_T2_UART_TRANSMIT_CLOCK_SELECT]) && !q.timer2_control[`DTM_T2_TF] && !wr
    |=> !q.timer2_control[`DTM_T2_TF]) else $error("overflow flag set in baud mode");
  timer2_external_flag_set_a: assert property (timer2_trigger_pin_fall_seq and t2_cap_seq |=> q.timer2_control[`DTM_T2_EXF] ##1 q.irq2)
    else $error("trigger edge did not set flag");
  ack_clear_a: assert property (t0_vector_ack && !set0 && !wr |=> !q.tf0)
    else $error("acknowledge did not clear flag");
endmodule // dtm_timers

// >>> dtm_pin_model.sv
`timescale 1ns/1ns
module dtm_pin_model #(
  parameter int MC_DIV = 6
) (
  // Clock
  input  wire logic       pclk,
  // Pins toward the block
  output logic      [5:0] pins
);
  // The pins idle high, as with a pull-up.
  initial pins = 6'h3F;

  // Each level is held for two machine cycles, so the sampler sees it at least once.
  task automatic fall(input int p);
    @(posedge pclk);
    pins[p] <= 1'b0;
    repeat (2 * MC_DIV) @(posedge pclk);
    pins[p] <= 1'b1;
    repeat (2 * MC_DIV) @(posedge pclk);
  endtask

  task automatic level(input int p, input logic v);
    @(posedge pclk);
    pins[p] <= v;
  endtask
endmodule // dtm_pin_model

// >>> testbench.sv
`timescale 1ns/1ns
`include "dtm_regs.svh"
module testbench;
  // A long machine cycle leaves room to stop a timer before its next tick.
  localparam int MC = 16;
  localparam logic [9:0] REGS [8] = '{`DTM_IDX_TIMER_CONTROL_REGISTER, `DTM_IDX_TIMER_MODE_REGISTER, `DTM_IDX_TL0, `DTM_IDX_TL1,
                                      `DTM_IDX_TH0, `DTM_IDX_TH1, `DTM_IDX_TIMER2_CONTROL, `DTM_IDX_TIMER2_MODE_CONTROL};
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  pins;
  logic        clk_out;
  logic        clk_out_en;
  logic        ack0;
  logic        ack1;
  logic        tf0;
  logic        tf1;
  logic        irq2;
  logic        rxp;
  logic        txp;
  logic [32:0] expq[$];
  int          n_errors;
  int          comparisons;

  dtm_timers #(.MC_DIV(MC)) i_dtm_timers (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .t0_count_pin(pins[`DTM_P_T0]), .t1_count_pin(pins[`DTM_P_T1]),
    .external_interrupt_pin0_n(pins[`DTM_P_INT0]), .external_interrupt_pin1_n(pins[`DTM_P_INT1]),
    .t2_count_pin(pins[`DTM_P_T2]), .timer2_trigger_pin(pins[`DTM_P_TIMER2_TRIGGER_PIN]),
    .t2_clock_out(clk_out), .t2_clock_out_en(clk_out_en), .t0_vector_ack(ack0), .t1_vector_ack(ack1),
    .timer0_overflow_flag(tf0), .timer1_overflow_flag(tf1), .timer2_interrupt_request(irq2),
    .uart_rx_baud_pulse(rxp), .uart_tx_baud_pulse(txp));

  dtm_pin_model #(.MC_DIV(MC)) i_dtm_pin_model (.pclk(pclk), .pins(pins));

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("Comparisons %0d, errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // The expected bus answer is queued before the transfer starts.
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d, input logic [32:0] exp);
    expq.push_back(exp);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, 33'h0);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] d);
    apb(1'b0, idx, 32'h0, {1'b0, d});
  endtask

  task automatic await(ref logic s, input logic v, input int n);
    repeat (n)
    begin
      @(posedge pclk);
      if (s === v)
        break;
    end
    check({32'h0, s}, {32'h0, v});
  endtask

  always @(posedge pclk)
    if (psel && penable && pready)
      check({pslverr, pwrite ? 32'h0 : prdata}, expq.pop_front());

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    close_out();
  end

  initial
  begin
    logic [7:0] rl;
    {psel, penable, pwrite, paddr, pwdata, ack0, ack1, presetn} = '0;
    void'($urandom(32'hA7D2));
    rl = 8'($urandom());
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (REGS[i]) rd(REGS[i], 32'h0);
    apb(1'b0, 10'h3FF, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 10'h3FF, 32'hFF, {1'b1, 32'h0});
    // Mode 0 rolls over from the 13-bit top; the upper low-byte bits stay put.
    wr(`DTM_IDX_TL0, 32'hFF);
    wr(`DTM_IDX_TH0, 32'hFF);
    wr(`DTM_IDX_TIMER_CONTROL_REGISTER, 32'h10);
    await(tf0, 1'b1, 3 * MC);
    ack0 <= 1'b1;
    @(posedge pclk);
    ack0 <= 1'b0;
    @(posedge pclk);
    check({32'h0, tf0}, 33'h0);
    wr(`DTM_IDX_TIMER_CONTROL_REGISTER, 32'h0);
    rd(`DTM_IDX_TH0, 32'h0);
    rd(`DTM_IDX_TL0, 32'hE0);
    // Timer 1 counts pin edges in mode 1, gated by its interrupt pin.
    wr(`DTM_IDX_TIMER_MODE_REGISTER, 32'hD0);
    wr(`DTM_IDX_TL1, 32'hFF);
    wr(`DTM_IDX_TH1, 32'hFF);
    i_dtm_pin_model.level(`DTM_P_INT1, 1'b0);
    wr(`DTM_IDX_TIMER_CONTROL_REGISTER, 32'h40);
    i_dtm_pin_model.fall(`DTM_P_T1);
    check({32'h0, tf1}, 33'h0);
    i_dtm_pin_model.level(`DTM_P_INT1, 1'b1);
    i_dtm_pin_model.fall(`DTM_P_T1);
    check({32'h0, tf1}, 33'h1);
    wr(`DTM_IDX_TIMER_CONTROL_REGISTER, 32'h0);
    check({32'h0, tf1}, 33'h0);
    rd(`DTM_IDX_TH1, 32'h0);
    // Mode 2 reload from a random high byte.
    wr(`DTM_IDX_TIMER_MODE_REGISTER, 32'h02);
    wr(`DTM_IDX_TH0, {24'h0, rl});
    wr(`DTM_IDX_TL0, 32'hFF);
    wr(`DTM_IDX_TIMER_CONTROL_REGISTER, 32'h10);
    await(tf0, 1'b1, 3 * MC);
    wr(`DTM_IDX_TIMER_CONTROL_REGISTER, 32'h0);
    rd(`DTM_IDX_TL0, {24'h0, rl});
    rd(`DTM_IDX_TH0, {24'h0, rl});
    // Split mode: the high byte of Timer 0 borrows Timer 1's run bit and flag.
    wr(`DTM_IDX_TIMER_MODE_REGISTER, 32'h33);
    wr(`DTM_IDX_TL0, 32'hFF);
    wr(`DTM_IDX_TH0, 32'hFF);
    wr(`DTM_IDX_TL1, 32'h12);
    wr(`DTM_IDX_TH1, 32'h34);
    wr(`DTM_IDX_TIMER_CONTROL_REGISTER, 32'h40);
    await(tf1, 1'b1, 3 * MC);
    check({32'h0, tf0}, 33'h0);
    wr(`DTM_IDX_TIMER_CONTROL_REGISTER, 32'h0);
    rd(`DTM_IDX_TL1, 32'h12);
    rd(`DTM_IDX_TH1, 32'h34);
    rd(`DTM_IDX_TL0, 32'hFF);
    wr(`DTM_IDX_TIMER_MODE_REGISTER, 32'h23);
    wr(`DTM_IDX_TH1, 32'hFF);
    wr(`DTM_IDX_TL1, 32'hFF);
    wr(`DTM_IDX_TIMER_CONTROL_REGISTER, 32'h40);
    await(txp, 1'b1, 3 * MC);
    wr(`DTM_IDX_TIMER_CONTROL_REGISTER, 32'h0);
    // Timer 2 auto-reload, then the baud and clock-out modes that never raise its flag.
    wr(`DTM_IDX_T2RLD, 32'hFFFE);
    wr(`DTM_IDX_T2CNT, 32'hFFFF);
    wr(`DTM_IDX_TIMER2_CONTROL, 32'h04);
    await(irq2, 1'b1, 4 * MC);
    rd(`DTM_IDX_TIMER2_CONTROL, 32'h84);
    wr(`DTM_IDX_TIMER2_CONTROL, 32'h0);
    wr(`DTM_IDX_TIMER2_CONTROL, 32'h35);
    rd(`DTM_IDX_TIMER2_CONTROL, 32'h35);
    await(rxp, 1'b1, 4 * MC);
    await(txp, 1'b1, 4 * MC);
    rd(`DTM_IDX_TIMER2_CONTROL, 32'h35);
    wr(`DTM_IDX_TIMER2_CONTROL, 32'h0);
    wr(`DTM_IDX_TIMER2_MODE_CONTROL, 32'h02);
    wr(`DTM_IDX_TIMER2_CONTROL, 32'h04);
    await(clk_out, 1'b1, 4 * MC);
    check({32'h0, clk_out_en}, 33'h1);
    rd(`DTM_IDX_TIMER2_CONTROL, 32'h04);
    wr(`DTM_IDX_TIMER2_CONTROL, 32'h0);
    wr(`DTM_IDX_TIMER2_MODE_CONTROL, 32'h03);
    rd(`DTM_IDX_TIMER2_MODE_CONTROL, 32'h03);
    // With the trigger pin low the counter runs down and underflows at the reload value.
    wr(`DTM_IDX_TIMER2_MODE_CONTROL, 32'h01);
    wr(`DTM_IDX_T2RLD, 32'h0010);
    wr(`DTM_IDX_T2CNT, 32'h0011);
    i_dtm_pin_model.level(`DTM_P_TIMER2_TRIGGER_PIN, 1'b0);
    wr(`DTM_IDX_TIMER2_CONTROL, 32'h04);
    await(irq2, 1'b1, 4 * MC);
    wr(`DTM_IDX_TIMER2_CONTROL, 32'h0);
    rd(`DTM_IDX_T2CNT, 32'hFFFF);
    i_dtm_pin_model.level(`DTM_P_TIMER2_TRIGGER_PIN, 1'b1);
    wr(`DTM_IDX_TIMER2_MODE_CONTROL, 32'h0);
    // Trigger edges are ignored until the enable bit is set.
    wr(`DTM_IDX_T2CNT, 32'h0);
    wr(`DTM_IDX_TIMER2_CONTROL, 32'h05);
    i_dtm_pin_model.fall(`DTM_P_TIMER2_TRIGGER_PIN);
    rd(`DTM_IDX_TIMER2_CONTROL, 32'h05);
    wr(`DTM_IDX_TIMER2_CONTROL, 32'h0D);
    i_dtm_pin_model.fall(`DTM_P_TIMER2_TRIGGER_PIN);
    rd(`DTM_IDX_TIMER2_CONTROL, 32'h4D);
    check({32'h0, irq2}, 33'h1);
    wr(`DTM_IDX_TIMER2_CONTROL, 32'h0);
    wr(`DTM_IDX_T2CNT, 32'hFFFF);
    wr(`DTM_IDX_TIMER2_CONTROL, 32'h06);
    i_dtm_pin_model.fall(`DTM_P_T2);
    rd(`DTM_IDX_TIMER2_CONTROL, 32'h86);
    wr(`DTM_IDX_TIMER2_CONTROL, 32'h0);
    wr(`DTM_IDX_T2CNT, 32'h1234);
    repeat (4 * MC) @(posedge pclk);
    rd(`DTM_IDX_T2CNT, 32'h1234);
    close_out();
  end
endmodule // testbench
